// ---- core/lvd_core.v ----
// Overview of operation
// - in reset mode, hold internal reset while supply below threshold
// - in interrupt mode, raise request when supply falls below threshold
// - an unmasked interrupt may fire right after enable
// - selecting reset mode while supply is fine gives no reset
// - every reset sets the interrupt mask flag to 1
// - a detector reset sets the reset-cause flag at bit 0
// - request flag is bit 1 of request flags 0, cleared by software
// - flag may become 1 during enable before reset mode selected
// - flag drives request only when enable is 1 and mode is 0
// - detector reset keeps control register; only power-on reset clears it
// - below-threshold flag is read-only
`include "lvd_map.vh"
module lvd_core (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // detector-kept state survives any rst_b reset; only this power-on reset clears it
    input wire por_b,
    // comparator, high while supply below selected level
    input wire comp_below,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // analog level select and comparator enable
    output reg [3:0] detect_level_field,
    output reg comparator_on,
    // internal reset request and interrupt
    output reg lowvolt_reset_req,
    output reg low_voltage_interrupt,
    output reg irq
);
    reg detector_enable_bit;
    reg detect_action_select;
    reg below_threshold_flag;
    reg low_voltage_irq_request;
    reg low_voltage_irq_mask;
    reg lowvolt_reset_cause_flag;
    reg [3:0] level_reg;
    reg [`LVD_ST_W-1:0] stat_reg;
    reg [`LVD_ST_W-1:0] ien_reg;
    reg flag_d_reg;
    wire below_sync;
    wire wr_ctrl;
    wire wr_level;
    wire wr_irqf;
    wire wr_mask;
    wire wr_cause;
    wire flag_next;
    wire rise_evt;
    wire fall_evt;
    wire reset_evt;
    wire [`LVD_ST_W-1:0] evt_vec;
    wire [`LVD_ST_W-1:0] clr_vec;
    reg [7:0] rdata_next;

    lvd_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(comp_below),
        .sync_out(below_sync)
    );

    assign wr_ctrl = reg_wr && (reg_addr == `LVD_ADDR_CTRL);
    assign wr_level = reg_wr && (reg_addr == `LVD_ADDR_LEVEL);
    assign wr_irqf = reg_wr && (reg_addr == `LVD_ADDR_IRQF);
    assign wr_mask = reg_wr && (reg_addr == `LVD_ADDR_IRQMASK);
    assign wr_cause = reg_wr && (reg_addr == `LVD_ADDR_CAUSE);

    // flag follows comparator only while enabled
    assign flag_next = detector_enable_bit & below_sync;
    assign fall_evt = flag_next & ~flag_d_reg;
    assign rise_evt = ~flag_next & flag_d_reg;
    // reset mode asserts only while below; none if above when selected
    assign reset_evt = detector_enable_bit & detect_action_select & below_sync;
    assign evt_vec = {reset_evt & ~lowvolt_reset_req, rise_evt, fall_evt};
    assign clr_vec = (reg_wr && (reg_addr == `LVD_ADDR_ICLR)) ?
        reg_wdata[`LVD_ST_W-1:0] : {`LVD_ST_W{1'b0}};

    // control and level survive a detector reset: only power-on clears them
    always @(posedge clk or negedge por_b) begin
        if (!por_b) begin
            detector_enable_bit <= 1'b0;
            detect_action_select <= 1'b0;
            level_reg <= `LVD_LEVEL_RST;
            lowvolt_reset_cause_flag <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                // flag bit is not writable
                detector_enable_bit <= reg_wdata[`LVD_CTRL_EN];
                detect_action_select <= reg_wdata[`LVD_CTRL_MODE];
            end
            if (wr_level) begin
                level_reg <= reg_wdata[`LVD_LEVEL_W-1:0];
            end
            if (reset_evt) begin
                lowvolt_reset_cause_flag <= 1'b1;
            end else if (wr_cause) begin
                lowvolt_reset_cause_flag <= reg_wdata[`LVD_CAUSE_BIT];
            end
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            below_threshold_flag <= 1'b0;
            flag_d_reg <= 1'b0;
            low_voltage_irq_request <= 1'b0;
            low_voltage_irq_mask <= 1'b1;
            low_voltage_interrupt <= 1'b0;
            lowvolt_reset_req <= 1'b0;
            comparator_on <= 1'b0;
            detect_level_field <= `LVD_LEVEL_RST;
            stat_reg <= {`LVD_ST_W{1'b0}};
            ien_reg <= {`LVD_ST_W{1'b0}};
            irq <= 1'b0;
            reg_rdata <= `LVD_ZERO8;
        end else begin
            below_threshold_flag <= flag_next;
            flag_d_reg <= flag_next;
            comparator_on <= detector_enable_bit;
            detect_level_field <= level_reg;
            lowvolt_reset_req <= reset_evt;
            // request line follows flag only in interrupt mode
            low_voltage_interrupt <= flag_next & ~detect_action_select;
            // set wins over software clear
            if (flag_next & ~detect_action_select & ~flag_d_reg) begin
                low_voltage_irq_request <= 1'b1;
            end else if (wr_irqf) begin
                low_voltage_irq_request <= reg_wdata[`LVD_IRQF_BIT];
            end
            if (wr_mask) begin
                low_voltage_irq_mask <= reg_wdata[`LVD_IRQF_BIT];
            end
            stat_reg <= (stat_reg & ~clr_vec) | evt_vec;
            if (reg_wr && (reg_addr == `LVD_ADDR_IEN)) begin
                ien_reg <= reg_wdata[`LVD_ST_W-1:0];
            end
            irq <= |(((stat_reg & ~clr_vec) | evt_vec) & ien_reg);
            reg_rdata <= reg_rd ? rdata_next : `LVD_ZERO8;
        end
    end

    always @* begin
        rdata_next = `LVD_ZERO8;
        case (reg_addr)
            `LVD_ADDR_CTRL: begin
                rdata_next[`LVD_CTRL_EN] = detector_enable_bit;
                rdata_next[`LVD_CTRL_MODE] = detect_action_select;
                rdata_next[`LVD_CTRL_FLAG] = below_threshold_flag;
            end
            `LVD_ADDR_LEVEL: rdata_next[`LVD_LEVEL_W-1:0] = level_reg;
            `LVD_ADDR_IRQF: rdata_next[`LVD_IRQF_BIT] = low_voltage_irq_request;
            `LVD_ADDR_IRQMASK: rdata_next[`LVD_IRQF_BIT] = low_voltage_irq_mask;
            `LVD_ADDR_CAUSE: rdata_next[`LVD_CAUSE_BIT] = lowvolt_reset_cause_flag;
            `LVD_ADDR_ISTAT: rdata_next[`LVD_ST_W-1:0] = stat_reg;
            `LVD_ADDR_IEN: rdata_next[`LVD_ST_W-1:0] = ien_reg;
            default: rdata_next = `LVD_ZERO8;
        endcase
    end
endmodule // lvd_core

// ---- core/lvd_map.vh ----
`ifndef LVD_MAP_VH
`define LVD_MAP_VH
// register addresses on the plain port
`define LVD_ADDR_CTRL 4'h0
`define LVD_ADDR_LEVEL 4'h1
`define LVD_ADDR_IRQF 4'h2
`define LVD_ADDR_IRQMASK 4'h3
`define LVD_ADDR_CAUSE 4'h4
`define LVD_ADDR_ISTAT 4'h5
`define LVD_ADDR_ICLR 4'h6
`define LVD_ADDR_IEN 4'h7
// control register fields
`define LVD_CTRL_EN 7
`define LVD_CTRL_MODE 1
`define LVD_CTRL_FLAG 0
// level field
`define LVD_LEVEL_W 4
`define LVD_LEVEL_MAX 4'h9
// request flag and cause bits
`define LVD_IRQF_BIT 1
`define LVD_CAUSE_BIT 0
// sticky status bits
`define LVD_ST_FALL 0
`define LVD_ST_RISE 1
`define LVD_ST_RESET 2
`define LVD_ST_W 3
// reset values
`define LVD_CTRL_RST 8'h00
`define LVD_LEVEL_RST 4'h0
`define LVD_ZERO8 8'h00
`endif

// ---- core/lvd_sync.v ----
module lvd_sync (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // asynchronous level in, filtered level out
    input wire async_in,
    output reg sync_out
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    // three stages; a change counts once stages two and three agree
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                sync_out <= s3_reg;
            end
        end
    end
endmodule // lvd_sync

// ---- bench/lvd_core_chk.sv ----
`include "lvd_map.vh"
module lvd_core_chk (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // watched ports
    input wire comp_below,
    input wire [3:0] reg_addr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire comparator_on,
    input wire lowvolt_reset_req,
    input wire low_voltage_interrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_ctrl_spare: assert property ($past(reg_rd) && $past(reg_addr) == `LVD_ADDR_CTRL
        |-> reg_rdata[6:2] == 5'h00) else $error("spare control bits set");
    a_off_no_rst: assert property (!comparator_on && $past(!comparator_on)
        |-> !lowvolt_reset_req) else $error("reset while off");
    a_off_no_int: assert property (!comparator_on && $past(!comparator_on)
        |-> !low_voltage_interrupt) else $error("interrupt while off");
    a_rst_cause: assert property (lowvolt_reset_req |-> $past(comp_below, 2) ||
        $past(comp_below, 3) || $past(comp_below, 4) || $past(comp_below, 5) ||
        $past(comp_below, 6) || $past(comp_below, 7)) else $error("reset without low");
    a_int_cause: assert property (low_voltage_interrupt |-> $past(comp_below, 2) ||
        $past(comp_below, 3) || $past(comp_below, 4) || $past(comp_below, 5) ||
        $past(comp_below, 6) || $past(comp_below, 7)) else $error("irq without low");
    a_mode_excl: assert property (low_voltage_interrupt && $past(low_voltage_interrupt)
        |-> !lowvolt_reset_req) else $error("both modes active");
    a_rst_en: assert property (lowvolt_reset_req |-> comparator_on || $past(comparator_on))
        else $error("reset with detector off");
endmodule // lvd_core_chk

// ---- bench/test_lvd_core.sv ----
`include "lvd_map.vh"
module test_lvd_core;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_b = 0, por_b = 0, comp_below = 0, reg_wr = 0, reg_rd = 0;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0;
    wire [7:0] reg_rdata;
    wire [3:0] detect_level_field;
    wire comparator_on, lowvolt_reset_req, low_voltage_interrupt, irq;
    int fails = 0, tests_run = 0, cyc = 0, lvl_m, a;
    // settle time after enable: 0.2 ms at a 20 ns clock
    localparam int EN_WAIT = 10000;
    always #10 clk = ~clk;
    lvd_core dut_u (.clk(clk), .rst_b(rst_b), .por_b(por_b), .comp_below(comp_below),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .detect_level_field(detect_level_field),
        .comparator_on(comparator_on), .lowvolt_reset_req(lowvolt_reset_req),
        .low_voltage_interrupt(low_voltage_interrupt), .irq(irq));
    task stop_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 25000) begin
            fails++;
            stop_test;
        end
    end
    task chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge clk);
        reg_wr <= 0;
    endtask
    task rd(input logic [3:0] ad, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1;
        @(posedge clk);
        reg_rd <= 0;
        #1 chk(reg_rdata, e);
    endtask
    task low(input logic v, input logic r);
        @(posedge clk);
        comp_below <= v;
        rst_b <= r;
        repeat (8) @(posedge clk);
    endtask
    initial begin
        void'($urandom(32'h3456d07d));
        repeat (4) @(posedge clk);
        rst_b <= 1;
        por_b <= 1;
        rd(`LVD_ADDR_CTRL, 8'h00);
        rd(`LVD_ADDR_IRQMASK, 8'h02);
        a = 8 + $urandom % 8;
        wr(a[3:0], 8'hff);
        rd(a[3:0], 8'h00);
        lvl_m = $urandom % 10;
        wr(`LVD_ADDR_LEVEL, lvl_m[7:0]);
        rd(`LVD_ADDR_LEVEL, lvl_m[7:0]);
        chk(detect_level_field, lvl_m[7:0]);
        low(1, 1);
        rd(`LVD_ADDR_CTRL, 8'h00);
        chk(low_voltage_interrupt, 8'h00);
        low(0, 1);
        wr(`LVD_ADDR_CTRL, 8'h81);
        repeat (EN_WAIT) @(posedge clk);
        chk(comparator_on, 8'h01);
        rd(`LVD_ADDR_CTRL, 8'h80);
        wr(`LVD_ADDR_CTRL, 8'h83);
        low(0, 1);
        chk(lowvolt_reset_req, 8'h00);
        low(1, 1);
        chk(lowvolt_reset_req, 8'h01);
        rd(`LVD_ADDR_CAUSE, 8'h01);
        rd(`LVD_ADDR_ISTAT, 8'h05);
        low(0, 0);
        low(0, 1);
        chk(lowvolt_reset_req, 8'h00);
        rd(`LVD_ADDR_CTRL, 8'h82);
        rd(`LVD_ADDR_LEVEL, lvl_m[7:0]);
        rd(`LVD_ADDR_IRQMASK, 8'h02);
        wr(`LVD_ADDR_CTRL, 8'h00);
        rd(`LVD_ADDR_CTRL, 8'h00);
        wr(`LVD_ADDR_CTRL, 8'h80);
        repeat (EN_WAIT) @(posedge clk);
        low(0, 1);
        rd(`LVD_ADDR_CTRL, 8'h80);
        wr(`LVD_ADDR_IRQF, 8'h00);
        wr(`LVD_ADDR_IRQMASK, 8'h00);
        rd(`LVD_ADDR_IRQMASK, 8'h00);
        wr(`LVD_ADDR_IEN, 8'h07);
        wr(`LVD_ADDR_ICLR, 8'h07);
        low(1, 1);
        chk({low_voltage_interrupt, irq}, 8'h03);
        rd(`LVD_ADDR_CTRL, 8'h81);
        rd(`LVD_ADDR_IRQF, 8'h02);
        rd(`LVD_ADDR_ISTAT, 8'h01);
        low(0, 1);
        wr(`LVD_ADDR_IRQF, 8'h00);
        rd(`LVD_ADDR_IRQF, 8'h00);
        wr(`LVD_ADDR_ICLR, 8'h07);
        wr(`LVD_ADDR_IEN, 8'h00);
        low(1, 1);
        chk(irq, 8'h00);
        wr(`LVD_ADDR_CTRL, 8'h00);
        low(1, 1);
        chk(low_voltage_interrupt, 8'h00);
        @(posedge clk);
        por_b <= 0;
        rst_b <= 0;
        low(0, 0);
        por_b <= 1;
        low(0, 1);
        rd(`LVD_ADDR_LEVEL, 8'h00);
        rd(`LVD_ADDR_CAUSE, 8'h00);
        stop_test;
    end
endmodule // test_lvd_core
bind lvd_core lvd_core_chk chk_u (.clk(clk), .rst_b(rst_b), .comp_below(comp_below),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .comparator_on(comparator_on), .lowvolt_reset_req(lowvolt_reset_req),
    .low_voltage_interrupt(low_voltage_interrupt));
